// [smbus_i2c_register_client.sv]
// two-wire client giving byte access to the monitor register space
`timescale 1ns/1ps
`default_nettype none
module smbus_i2c_register_client (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_serial_bus_clock_pin,
  input wire logic i_sda_in,
  output logic o_sda_out,
  output logic o_sda_oe,
  input wire logic [6:0] i_addr_strap,
  input wire logic i_clock_low_timeout_enable,
  input wire logic i_alert_pending,
  output logic [7:0] o_ptr,
  output logic o_busy
);
  // -------------------------------------------------------------------
  // state encoding
  // -------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_AACK = 3'b011,
    ST_RX = 3'b010,
    ST_RACK = 3'b110,
    ST_TX = 3'b111,
    ST_TACK = 3'b101,
    ST_WAIT = 3'b100
  } state_t;

  state_t state_r, state_nxt;
  logic scl_d_r, sda_d_r, scl_d_nxt, sda_d_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic [3:0] bitc_r, bitc_nxt;
  logic [7:0] ptr_r, ptr_nxt;
  logic first_r, first_nxt;
  logic rd_r, rd_nxt;
  logic alert_r, alert_nxt;
  logic sda_oe_r, sda_oe_nxt;
  logic busy_r, busy_nxt;
  logic [6:0] addr_r, addr_nxt;
  logic [smbus_client_pkg::TIMEOUT_CNT_W-1:0] tcnt_r, tcnt_nxt;
  logic we, rise, fall, start_c, stop_c, tmo;
  logic [7:0] rdata;
  logic [7:0] tx_byte;

  // -------------------------------------------------------------------
  // register memory
  // -------------------------------------------------------------------
  smbus_reg_mem u_mem (
    .i_clk_sys(i_clk_sys),
    .i_we(we),
    .i_waddr(ptr_r),
    .i_wdata(shift_r),
    .i_raddr(ptr_r),
    .o_rdata(rdata)
  );

  // edge and condition detection on the sampled pins
  always_comb begin
    scl_d_nxt = i_serial_bus_clock_pin;
    sda_d_nxt = i_sda_in;
    rise = !scl_d_r && i_serial_bus_clock_pin;
    fall = scl_d_r && !i_serial_bus_clock_pin;
    start_c = scl_d_r && i_serial_bus_clock_pin && sda_d_r && !i_sda_in;
    stop_c = scl_d_r && i_serial_bus_clock_pin && !sda_d_r && i_sda_in;
  end

  // clock-low counter; off unless enabled, so i2c hosts may hold forever
  always_comb begin
    tcnt_nxt = '0;
    tmo = 1'b0;
    if (i_clock_low_timeout_enable && !scl_d_r && state_r != ST_IDLE) begin
      tcnt_nxt = tcnt_r + 1'b1;
      tmo = (tcnt_r >= smbus_client_pkg::TIMEOUT_CNT_W'(
        smbus_client_pkg::TIMEOUT_CYCLES));
    end
  end

  // alert answer is own address shifted with a one in the low bit
  assign tx_byte = alert_r ? {addr_r, 1'b1} : rdata;

  // -------------------------------------------------------------------
  // protocol engine
  // -------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    shift_nxt = shift_r;
    bitc_nxt = bitc_r;
    ptr_nxt = ptr_r;
    first_nxt = first_r;
    rd_nxt = rd_r;
    alert_nxt = alert_r;
    sda_oe_nxt = sda_oe_r;
    addr_nxt = addr_r;
    we = 1'b0;
    if (state_r == ST_IDLE) begin
      addr_nxt = i_addr_strap; // caught while idle, never at reset
    end
    if (tmo || stop_c) begin
      state_nxt = ST_IDLE;
      sda_oe_nxt = 1'b0;
    end else if (start_c) begin
      state_nxt = ST_ADDR; // repeated start allowed anywhere
      bitc_nxt = '0;
      sda_oe_nxt = 1'b0;
    end else begin
      unique case (state_r)
        ST_IDLE, ST_WAIT: begin
        end
        ST_ADDR: begin
          if (rise) begin
            shift_nxt = {shift_r[6:0], i_sda_in}; // msb first
            bitc_nxt = bitc_r + 1'b1;
          end
          if (fall && bitc_r == smbus_client_pkg::BYTE_BITS) begin
            rd_nxt = shift_r[0];
            alert_nxt = 1'b0;
            first_nxt = 1'b1;
            bitc_nxt = '0;
            if (shift_r[7:1] == addr_r) begin
              state_nxt = ST_AACK;
              sda_oe_nxt = 1'b1;
            end else if (shift_r[7:1] == smbus_client_pkg::ALERT_RESP_ADDR
                && shift_r[0] && i_alert_pending) begin
              state_nxt = ST_AACK;
              alert_nxt = 1'b1;
              sda_oe_nxt = 1'b1;
            end else begin
              state_nxt = ST_WAIT; // no ack, pointer and memory untouched
            end
          end
        end
        ST_AACK: begin
          if (fall) begin
            if (rd_r) begin
              state_nxt = ST_TX; // read from current pointer
              sda_oe_nxt = !tx_byte[7];
              shift_nxt = {tx_byte[6:0], 1'b0};
              bitc_nxt = 4'h1;
            end else begin
              state_nxt = ST_RX;
              sda_oe_nxt = 1'b0;
            end
          end
        end
        ST_RX: begin
          if (rise) begin
            shift_nxt = {shift_r[6:0], i_sda_in};
            bitc_nxt = bitc_r + 1'b1;
          end
          if (fall && bitc_r == smbus_client_pkg::BYTE_BITS) begin
            bitc_nxt = '0;
            state_nxt = ST_RACK;
            sda_oe_nxt = 1'b1; // every byte acked
            if (first_r) begin
              ptr_nxt = shift_r; // pointer byte
              first_nxt = 1'b0;
            end else begin
              we = 1'b1;
              ptr_nxt = ptr_r + 1'b1;
            end
          end
        end
        ST_RACK: begin
          if (fall) begin
            state_nxt = ST_RX;
            sda_oe_nxt = 1'b0;
          end
        end
        ST_TX: begin
          if (fall) begin
            if (bitc_r == smbus_client_pkg::BYTE_BITS) begin
              state_nxt = ST_TACK;
              sda_oe_nxt = 1'b0;
              if (!alert_r) begin
                ptr_nxt = ptr_r + 1'b1;
              end
            end else begin
              sda_oe_nxt = !shift_r[7];
              shift_nxt = {shift_r[6:0], 1'b0};
              bitc_nxt = bitc_r + 1'b1;
            end
          end
        end
        ST_TACK: begin
          if (rise) begin
            if (i_sda_in || alert_r) begin
              state_nxt = ST_WAIT; // nack ends reading
            end else begin
              state_nxt = ST_AACK; // ack: next byte on next fall
            end
          end
        end
      endcase
    end
    // busy flag registered beside the state, so the pin comes from a flop
    busy_nxt = (state_nxt != ST_IDLE);
  end

  // registers for the engine
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      state_r <= ST_IDLE;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      shift_r <= '0;
      bitc_r <= '0;
      ptr_r <= smbus_client_pkg::PTR_RESET;
      first_r <= 1'b0;
      rd_r <= 1'b0;
      alert_r <= 1'b0;
      sda_oe_r <= 1'b0;
      busy_r <= 1'b0;
      addr_r <= '0;
      tcnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      scl_d_r <= scl_d_nxt;
      sda_d_r <= sda_d_nxt;
      shift_r <= shift_nxt;
      bitc_r <= bitc_nxt;
      ptr_r <= ptr_nxt;
      first_r <= first_nxt;
      rd_r <= rd_nxt;
      alert_r <= alert_nxt;
      sda_oe_r <= sda_oe_nxt;
      busy_r <= busy_nxt;
      addr_r <= addr_nxt;
      tcnt_r <= tcnt_nxt;
    end
  end

  // outputs from flip-flops, o_sda_out tied low; open drain drives only low
  assign o_sda_out = 1'b0;
  assign o_sda_oe = sda_oe_r;
  assign o_ptr = ptr_r;
  assign o_busy = busy_r;
endmodule
`default_nettype wire

// [smbus_client_pkg.sv]
// constants shared by the two-wire register client
`default_nettype none
package smbus_client_pkg;
  // timing at the 100 MHz system clock
  localparam int unsigned SYS_CLK_HZ = 100_000_000;
  localparam int unsigned TIMEOUT_MS = 30;
  localparam int unsigned TIMEOUT_CYCLES = SYS_CLK_HZ / 1000 * TIMEOUT_MS;
  localparam int unsigned TIMEOUT_CNT_W = 22;
  // fastest bus clock handled: 400 kHz gives 250 cycles per bit
  localparam int unsigned MAX_BUS_HZ = 400_000;
  localparam int unsigned MIN_BUS_HZ = 10_000;
  // register space
  localparam int unsigned REG_AW = 8;
  localparam int unsigned REG_DW = 8;
  localparam int unsigned REG_DEPTH = 256;
  localparam logic [7:0] PTR_RESET = 8'h00;
  // alert response address, seven bits
  localparam logic [6:0] ALERT_RESP_ADDR = 7'h0C;
  localparam logic [3:0] BIT_LAST = 4'h7;
  // bits counted in one byte before the acknowledge slot
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [7:0] ALERT_BYTE_PAD = 8'h01;
endpackage
`default_nettype wire

// [smbus_reg_mem.sv]
// byte-wide register memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module smbus_reg_mem (
  input wire logic i_clk_sys,
  input wire logic i_we,
  input wire logic [7:0] i_waddr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] i_raddr,
  output logic [7:0] o_rdata
);
  logic [7:0] mem_r [0:smbus_client_pkg::REG_DEPTH-1];

  // write port and registered read port
  always_ff @(posedge i_clk_sys) begin
    if (i_we) begin
      mem_r[i_waddr] <= i_wdata;
    end
    o_rdata <= mem_r[i_raddr];
  end
endmodule
`default_nettype wire

// [smbus_client_asserts.sv]
// concurrent checks on the two-wire register client ports
`timescale 1ns/1ps
`default_nettype none
module smbus_client_asserts (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_serial_bus_clock_pin,
  input wire logic i_sda_in,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic [6:0] i_addr_strap,
  input wire logic i_clock_low_timeout_enable,
  input wire logic i_alert_pending,
  input wire logic [7:0] o_ptr,
  input wire logic o_busy
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  // reset check overrides the default disable
  chk_reset_idle_out: assert property (@(posedge i_clk_sys) disable iff (1'b0) i_reset |=> !o_sda_oe && o_ptr == 8'h00 && !o_busy) else $error("outputs not idle after reset");
  chk_sda_out_low: assert property (o_sda_out == 1'b0) else $error("data output not low");
  chk_stop_to_idle: assert property (i_serial_bus_clock_pin && $past(i_serial_bus_clock_pin) && $rose(i_sda_in) |-> ##[0:4] !o_busy) else $error("stop left interface busy");
  // data may only move while the clock is low, else it reads as start or stop
  chk_oe_clock_low: assert property ($changed(o_sda_oe) |-> !i_serial_bus_clock_pin) else $error("data drive changed with clock high");
  chk_ack_holds_bit: assert property ($rose(o_sda_oe) |=> o_sda_oe [*8]) else $error("acknowledge dropped early");
  chk_ptr_clock_low: assert property ($changed(o_ptr) |-> !i_serial_bus_clock_pin) else $error("pointer moved with clock high");
  chk_idle_quiet_bus: assert property (!o_busy && $past(o_busy) == 1'b0 |-> !o_sda_oe) else $error("data driven while idle");
  chk_no_timeout_off: assert property ($fell(o_busy) && !i_clock_low_timeout_enable |-> i_serial_bus_clock_pin) else $error("idle with clock low and timeout off");
  cover property ($rose(o_sda_oe));
  cover property ($fell(o_busy));
  cover property ($changed(o_ptr));
endmodule
bind smbus_i2c_register_client smbus_client_asserts chk (.i_clk_sys,
  .i_reset, .i_serial_bus_clock_pin, .i_sda_in, .o_sda_out, .o_sda_oe,
  .i_addr_strap, .i_clock_low_timeout_enable, .i_alert_pending, .o_ptr,
  .o_busy);
`default_nettype wire

// [smbus_host_model.sv]
// bus controller model driving clock and data, open drain with pull-up
`timescale 1ns/1ps
`default_nettype none
module smbus_host_model (
  input wire logic i_clk_sys,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  // quarter bit; 63 gives just under 400 kHz, far above 10 kHz
  int q_len = 63;
  // extra low time per bit, standing in for a peer stretching the clock
  int lo_len = 0;
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  task q;
    repeat (q_len) @(posedge i_clk_sys);
  endtask
  // data falls while clock high; works from idle or as repeated start
  task start;
    o_sda_low <= 1'b0;
    q;
    o_scl <= 1'b1;
    q;
    o_sda_low <= 1'b1;
    q;
    o_scl <= 1'b0;
    q;
  endtask
  // data rises while clock high
  task stop;
    o_sda_low <= 1'b1;
    q;
    o_scl <= 1'b1;
    q;
    o_sda_low <= 1'b0;
    q;
  endtask
  // sample in mid high phase; data changes a quarter after the fall
  task bitx(input logic b, output logic r);
    o_sda_low <= !b;
    q;
    o_scl <= 1'b1;
    q;
    r = i_sda;
    q;
    o_scl <= 1'b0;
    q;
    repeat (lo_len) @(posedge i_clk_sys); // stretched low phase
  endtask
  task wbyte(input logic [7:0] v, output logic ack);
    for (int i = 7; i >= 0; i--) bitx(v[i], ack);
    bitx(1'b1, ack);
  endtask
  task rbyte(input logic nack, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'b1, v[i]);
    bitx(nack, r);
  endtask
endmodule
`default_nettype wire

// [smbus_i2c_register_client_tb_top.sv]
// self-checking bench for the two-wire register client
`timescale 1ns/1ps
`default_nettype none
module smbus_i2c_register_client_tb_top;
  logic i_clk_sys = 1'b0;
  logic i_reset = 1'b1;
  logic alert = 1'b0;
  logic clock_low_timeout_enable_en = 1'b0;
  logic [6:0] strap = 7'h4C;
  logic scl, sda_low, sda_oe, sda_out, busy, a;
  logic [7:0] ptr, d;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  // wired-and of both pullers, pull-up when released
  wire sda = !(sda_low | (sda_oe & !sda_out));
  always #5 i_clk_sys = !i_clk_sys;
  smbus_host_model host (.i_clk_sys, .i_sda(sda), .o_scl(scl),
    .o_sda_low(sda_low));
  smbus_i2c_register_client dut (.i_clk_sys, .i_reset,
    .i_serial_bus_clock_pin(scl), .i_sda_in(sda), .o_sda_out(sda_out),
    .o_sda_oe(sda_oe), .i_addr_strap(strap),
    .i_clock_low_timeout_enable(clock_low_timeout_enable_en), .i_alert_pending(alert),
    .o_ptr(ptr), .o_busy(busy));
  task finish_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  // byte expected to be acknowledged
  task wr(input logic [7:0] v);
    host.wbyte(v, a);
    chk8("ack", 8'h00, {7'h00, a});
  endtask
  task rd1(input logic [7:0] p, input logic [7:0] e);
    host.start; wr(8'h98); wr(p); host.start; wr(8'h99);
    host.rbyte(1'b1, d); host.stop;
    chk8("read", e, d);
  endtask
  task t_write_byte;
    host.start; wr(8'h98); wr(8'h10); wr(8'hA5); host.stop;
    chk8("ptr", 8'h11, ptr);
    chk8("busy", 8'h00, {7'h00, busy});
  endtask
  task t_block_write;
    host.start; wr(8'h98); wr(8'h20);
    for (int i = 0; i < 4; i++) wr(8'hC0 + 8'(i));
    host.stop;
    chk8("ptr", 8'h24, ptr);
  endtask
  task t_block_read;
    host.start; wr(8'h98); wr(8'h20); host.start; wr(8'h99);
    for (int i = 0; i < 4; i++) begin
      host.rbyte(i == 3, d);
      chk8("block", 8'hC0 + 8'(i), d);
    end
    host.stop;
  endtask
  task t_send_receive;
    host.start; wr(8'h98); wr(8'h21); host.stop;
    chk8("ptr", 8'h21, ptr);
    host.start; wr(8'h99); host.rbyte(1'b1, d); host.stop;
    chk8("recv", 8'hC1, d);
  endtask
  task t_bad_addr;
    host.start; host.wbyte(8'h9A, a);
    chk8("nack", 8'h01, {7'h00, a});
    host.wbyte(8'h10, a); host.wbyte(8'h00, a); host.stop;
    rd1(8'h10, 8'hA5);
  endtask
  task t_alert;
    alert <= 1'b1;
    host.start; wr(8'h19); host.rbyte(1'b1, d); host.stop;
    chk8("alert", 8'h99, d);
    alert <= 1'b0;
  endtask
  // stretched low phases with the timeout armed: short lows never reset
  task t_stretch;
    clock_low_timeout_enable_en <= 1'b1;
    host.lo_len = 80;
    rd1(8'h22, 8'hC2);
    host.lo_len = 0;
    clock_low_timeout_enable_en <= 1'b0;
  endtask
  // a new strap value is taken up while the interface is idle
  task t_strap;
    strap <= 7'h4D;
    host.start; wr(8'h9A); wr(8'h30); host.stop;
    chk8("ptr", 8'h30, ptr);
    strap <= 7'h4C;
  endtask
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 110000) begin
      mismatches++;
      finish_test;
    end
  end
  initial begin
    repeat (8) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
    t_write_byte; rd1(8'h10, 8'hA5); t_block_write; t_block_read;
    t_send_receive; t_bad_addr; t_alert; t_stretch; t_strap;
    finish_test;
  end
endmodule
`default_nettype wire
